// >>> verilog/dsl_top.sv
// Serial load front end of a 16-bit DAC: shift register, input and DAC registers, load and clear.
`include "dsl_params.svh"

module dsl_top (
   // System clock and reset
   input wire logic clk,
   input wire logic rst,
   // Serial link pins
   input wire logic sclk,
   input wire logic frame_n,
   input wire logic serial_in,
   output logic serial_out,
   output logic serial_out_oe,
   // Control pins
   input wire logic load_output_n,
   input wire logic force_clear_code_n,
   input wire logic reset_pin_n,
   // Converter side
   output dsl_pkg::dsl_code_type input_code,
   output dsl_pkg::dsl_code_type dac_code,
   output dsl_pkg::dsl_code_type output_code,
   output logic output_update
);
   import dsl_pkg::*;

   // ======================================================================
   // Pin synchronisation and edge detection
   logic [5:0] pins_s;
   logic sclk_s;
   logic frame_s;
   logic sdi_s;
   logic load_s;
   logic clear_s;
   logic rpin_s;
   logic sclk_prev_q;
   logic load_prev_q;

   dsl_sync #(.W(6)) u_sync (
      .clk(clk),
      .rst(rst),
      .async_in({sclk, frame_n, serial_in, load_output_n, force_clear_code_n, reset_pin_n}),
      .sync_out(pins_s)
   );

   assign sclk_s = pins_s[5];
   assign frame_s = pins_s[4];
   assign sdi_s = pins_s[3];
   assign load_s = pins_s[2];
   assign clear_s = pins_s[1];
   assign rpin_s = pins_s[0];

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sclk_prev_q <= 1'b1;
         load_prev_q <= 1'b1;
      end
      else
      begin
         sclk_prev_q <= sclk_s;
         load_prev_q <= load_s;
      end
   end

   // Converter code seen by the analog side is always straight binary.
   function automatic dsl_code_type to_binary(input dsl_code_type code, input logic twos);
      to_binary = twos ? (code ^ `DSL_TWOS_MASK) : code;
   endfunction

   // ======================================================================
   // Frame control and shifting
   dsl_state_type state_q;
   dsl_state_type state_d;
   dsl_word_type shift_q;
   dsl_word_type shift_d;
   logic [4:0] cnt_q;
   logic [4:0] cnt_d;
   logic sclk_fall;
   logic load_fall;
   logic shift_en;
   logic close;
   logic word_ok;
   logic is_write;
   logic [2:0] addr;

   assign sclk_fall = sclk_prev_q & ~sclk_s;
   assign load_fall = load_prev_q & ~load_s;
   assign shift_en = sclk_fall & ~frame_s;
   assign close = (state_q == DSL_ST_SHIFT) & frame_s;
   assign word_ok = (cnt_q == `DSL_CNT_FULL);
   // MSB first: each new bit enters at bit 0 and older bits move up.
   assign shift_d = shift_en ? {shift_q[`DSL_WORD_MSB-1:0], sdi_s} : shift_q;
   assign is_write = ~shift_q[`DSL_RW_BIT];
   assign addr = shift_q[`DSL_ADDR_HI:`DSL_ADDR_LO];

   always_comb
   begin
      state_d = state_q;
      cnt_d = cnt_q;
      unique case (state_q)
         DSL_ST_IDLE:
         begin
            cnt_d = shift_en ? 5'h01 : 5'h00;
            if (!frame_s)
            begin
               state_d = DSL_ST_SHIFT;
            end
         end
         DSL_ST_SHIFT:
         begin
            // Extra bits keep only the last 24; the count saturates at a full word.
            if (shift_en && !word_ok)
            begin
               cnt_d = cnt_q + 5'h01;
            end
            if (frame_s)
            begin
               state_d = DSL_ST_IDLE;
               cnt_d = 5'h00;
            end
         end
         default:
         begin
            state_d = DSL_ST_IDLE;
            cnt_d = 5'h00;
         end
      endcase
   end

   // ======================================================================
   // Register stages
   dsl_code_type input_q;
   dsl_code_type input_d;
   dsl_code_type dac_q;
   dsl_code_type dac_d;
   dsl_code_type clr_q;
   dsl_code_type clr_d;
   dsl_code_type outc_q;
   logic twos_q;
   logic twos_d;
   logic upd_q;
   logic upd_d;
   logic wr_ok;
   logic wr_dac;

   assign wr_ok = close & word_ok & is_write;
   assign wr_dac = wr_ok & (addr == `DSL_ADDR_DAC);
   assign input_d = wr_dac ? shift_q[`DSL_CODE_HI:`DSL_CODE_LO] : input_q;
   assign clr_d = (wr_ok && addr == `DSL_ADDR_CLR) ? shift_q[`DSL_CODE_HI:`DSL_CODE_LO] : clr_q;
   assign twos_d = (wr_ok && addr == `DSL_ADDR_CTRL) ? shift_q[`DSL_CTRL_TWOS_BIT] : twos_q;

   // Clear wins over load events, so a held clear pins the output to the clear code.
   always_comb
   begin
      dac_d = dac_q;
      upd_d = 1'b0;
      if (!clear_s)
      begin
         dac_d = clr_q;
         upd_d = 1'b1;
      end
      else if (wr_dac && !load_s)
      begin
         dac_d = input_d;
         upd_d = 1'b1;
      end
      else if (load_fall)
      begin
         dac_d = input_q;
         upd_d = 1'b1;
      end
   end

   // The reset pin is sampled through the synchroniser, so it acts a few clocks late.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_q <= DSL_ST_IDLE;
         shift_q <= `DSL_WORD_RESET;
         cnt_q <= 5'h00;
         input_q <= `DSL_CODE_RESET;
         dac_q <= `DSL_CODE_RESET;
         clr_q <= `DSL_CODE_RESET;
         twos_q <= 1'b0;
         upd_q <= 1'b0;
         outc_q <= `DSL_CODE_RESET;
      end
      else if (!rpin_s)
      begin
         state_q <= DSL_ST_IDLE;
         shift_q <= `DSL_WORD_RESET;
         cnt_q <= 5'h00;
         input_q <= `DSL_CODE_RESET;
         dac_q <= `DSL_CODE_RESET;
         clr_q <= `DSL_CODE_RESET;
         twos_q <= 1'b0;
         upd_q <= 1'b0;
         outc_q <= `DSL_CODE_RESET;
      end
      else
      begin
         state_q <= state_d;
         shift_q <= shift_d;
         cnt_q <= cnt_d;
         input_q <= input_d;
         dac_q <= dac_d;
         clr_q <= clr_d;
         twos_q <= twos_d;
         upd_q <= upd_d;
         outc_q <= to_binary(dac_q, twos_q);
      end
   end

   // ======================================================================
   // Serial output: the shifted-out top bit, driven only inside a frame
   logic so_q;
   logic so_oe_q;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         so_q <= 1'b0;
         so_oe_q <= 1'b0;
      end
      else
      begin
         so_q <= shift_q[`DSL_WORD_MSB];
         so_oe_q <= ~frame_s & rpin_s;
      end
   end

   assign serial_out = so_q;
   assign serial_out_oe = so_oe_q;
   assign input_code = input_q;
   assign dac_code = dac_q;
   assign output_code = outc_q;
   assign output_update = upd_q;

   // ======================================================================
   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence s_dac_write;
      rpin_s && clear_s && wr_dac;
   endsequence

   sequence s_quiet;
      rpin_s && clear_s && !load_fall && !wr_dac;
   endsequence

   AST_SHIFT: assert property (rpin_s && shift_en |=> shift_q == {$past(shift_q[22:0]), $past(sdi_s)})
      else $error("shift register did not take the sampled bit");
   AST_IDLE_HOLD: assert property (rpin_s && frame_s |=> $stable(shift_q))
      else $error("shift register moved outside a frame");
   AST_CLOSE_INPUT: assert property (s_dac_write |=> input_q == $past(shift_q[19:4]))
      else $error("input register missed the closing word");
   AST_LOAD_LOW: assert property (s_dac_write ##0 !load_s |=> dac_q == input_q && output_update)
      else $error("output not updated at frame close with load low");
   AST_DEFER: assert property (s_dac_write ##0 load_s ##1 s_quiet |=> $stable(dac_q))
      else $error("output changed without a load edge");
   AST_LOAD_FALL: assert property (rpin_s && clear_s && load_fall && !wr_dac |=>
      dac_q == $past(input_q))
      else $error("load falling edge did not move the input register");
   AST_HOLD: assert property (s_quiet |=> $stable(dac_q) && !output_update)
      else $error("dac register changed with no event");
   AST_CLEAR: assert property (rpin_s && !clear_s |=> dac_q == $past(clr_q))
      else $error("clear did not load the clear code");
   AST_CODING: assert property (rpin_s ##1 rpin_s |-> outc_q == to_binary($past(dac_q), $past(twos_q)))
      else $error("output coding wrong");
   AST_RESET_PIN: assert property (!rpin_s |=> dac_q == `DSL_CODE_RESET && cnt_q == 5'h00
      && state_q == DSL_ST_IDLE)
      else $error("reset pin did not restore power-on state");
   AST_COUNT: assert property (rpin_s && close |=> (cnt_q == 5'h00) [*2])
      else $error("bit count not cleared after frame close");
endmodule

// >>> verilog/dsl_params.svh
// Constants of the serial load front end: word layout, addresses, reset values, host timing.
// Behaviour
// - A 24-bit shift register collects one command word per frame from serial_in.
// - Each falling serial clock edge inside a frame samples serial_in and shifts.
// - Frame sync low opens a frame and enables shifting on following falling edges.
// - Rising frame sync closes the frame and transfers the word toward the output.
// - With load_output_n low, each new value reaches the output at frame close.
// - With load_output_n high, only the input register updates; output waits for load fall.
// - Reset pin low returns every register and the output to power-on state; the code leaves the edge flops sclk_prev_q, load_prev_q and so_q out of it.
// - force_clear_code_n low loads the clear code into the DAC register at once.
// - Clear code is read in the current coding, straight binary or twos complement.
// - Bit 23 is read/write, bits 22 to 20 address, bits 19 to 0 data.
// - Words shift most significant bit first, bit 23 arrives first.
`ifndef DSL_PARAMS_SVH
`define DSL_PARAMS_SVH

// ==========================================================================
// Word layout
`define DSL_WORD_BITS 24
`define DSL_WORD_MSB 23
`define DSL_CNT_FULL 5'h18
`define DSL_RW_BIT 23
`define DSL_ADDR_HI 22
`define DSL_ADDR_LO 20
`define DSL_CODE_HI 19
`define DSL_CODE_LO 4
`define DSL_CTRL_TWOS_BIT 1

// ==========================================================================
// Register addresses and reset values
`define DSL_ADDR_DAC 3'h1
`define DSL_ADDR_CTRL 3'h2
`define DSL_ADDR_CLR 3'h3
`define DSL_CODE_RESET 16'h0000
`define DSL_WORD_RESET 24'h000000
`define DSL_TWOS_MASK 16'h8000

// ==========================================================================
// Host serial clock ceilings, in MHz
`define DSL_SCLK_WRITE_MAX_MHZ 35
`define DSL_SCLK_READ_MAX_MHZ 16

`endif

// >>> verilog/dsl_pkg.sv
// Types shared by the serial load front end.
package dsl_pkg;
   typedef logic [15:0] dsl_code_type;
   typedef logic [23:0] dsl_word_type;
   typedef enum logic [1:0]
   {
      DSL_ST_IDLE = 2'b01,
      DSL_ST_SHIFT = 2'b10
   } dsl_state_type;
endpackage

// >>> verilog/dsl_sync.sv
// Two flip-flop synchroniser for a group of asynchronous pins.
module dsl_sync #(
   parameter int W = 6
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Pins in, settled levels out
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta_q;

   // Pins idle high, so both stages reset to ones.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         meta_q <= '1;
         sync_out <= '1;
      end
      else
      begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule

// >>> tb/dsl_host.sv
// Host serial controller model that drives write and readback frames into the load front end.
module dsl_host (
   // Clock used only to pace the pins
   input wire logic clk,
   // Serial link pins
   output logic sclk,
   output logic frame_n,
   output logic serial_in
);
   timeunit 1ns;
   timeprecision 1ns;

   initial
   begin
      sclk = 1'b1;
      frame_n = 1'b1;
      serial_in = 1'b1;
   end

   // ==========================================================================
   // Frame driver
   task automatic half();
      repeat (4) @(posedge clk);
      #1;
   endtask

   // The clock idles high and toggles only inside a frame, at 800 ns, far below any ceiling.
   // A readback request is also sent, and 800 ns is far below the slower readback ceiling too.
   task automatic send(input logic [23:0] w, input int n);
      frame_n = 1'b0;
      for (int i = 23; i > 23 - n; i--)
      begin
         serial_in = w[i];
         half();
         sclk = 1'b0;
         half();
         sclk = 1'b1;
      end
      half();
      frame_n = 1'b1;
      // Idle data shows the inverse of the last bit so a stale sample cannot pass.
      serial_in = ~serial_in;
      half();
   endtask
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the serial load front end.
`include "dsl_params.svh"

module testbench;
   import dsl_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;

   logic clk = 1'b0;
   logic rst;
   logic load_output_n;
   logic force_clear_code_n;
   logic reset_pin_n;
   logic sclk;
   logic frame_n;
   logic serial_in;
   logic serial_out;
   logic serial_out_oe;
   logic output_update;
   logic twos;
   dsl_code_type input_code;
   dsl_code_type dac_code;
   dsl_code_type output_code;
   dsl_code_type last;
   dsl_code_type code;
   int errors = 0;
   int compares = 0;
   int seed = 32'h6ec76b43;
   int upd_seen = 0;
   int oe_seen = 0;
   int upd_base = 0;

   always #50 clk = ~clk;

   // Pulses are counted half a cycle after the launching edge, once the flops have settled.
   always @(negedge clk)
   begin
      if (output_update === 1'b1)
         upd_seen++;
      if (serial_out_oe === 1'b1)
         oe_seen++;
   end

   dsl_host host (.clk(clk), .sclk(sclk), .frame_n(frame_n), .serial_in(serial_in));

   dsl_top dut (
      .clk(clk), .rst(rst), .sclk(sclk), .frame_n(frame_n), .serial_in(serial_in),
      .serial_out(serial_out), .serial_out_oe(serial_out_oe),
      .load_output_n(load_output_n), .force_clear_code_n(force_clear_code_n),
      .reset_pin_n(reset_pin_n), .input_code(input_code), .dac_code(dac_code),
      .output_code(output_code), .output_update(output_update)
   );

   // ==========================================================================
   // Helpers
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic chk(input dsl_code_type seen, input dsl_code_type exp);
      compares++;
      if (seen !== exp)
      begin
         errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic dsl_word_type mk(input logic [2:0] a, input dsl_code_type d);
      return {1'b0, a, d, 4'h0};
   endfunction

   function automatic dsl_code_type out_of(input dsl_code_type c);
      return twos ? (c ^ `DSL_TWOS_MASK) : c;
   endfunction

   // The host keeps the frame low for eight clocks per bit plus one closing half bit.
   function automatic dsl_code_type frame_cycles(input int n);
      return 16'(n * 8 + 4);
   endfunction

   task automatic wr(input logic [2:0] a, input dsl_code_type d);
      int oe_base;
      oe_base = oe_seen;
      host.send(mk(a, d), 24);
      cyc(8);
      chk(16'(oe_seen - oe_base), frame_cycles(24));
      chk(serial_out_oe, 1'b0);
      chk(serial_out, 1'b0);
   endtask

   task automatic end_of_test();
      if (errors == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // ==========================================================================
   // Scenarios
   initial
   begin
      rst = 1'b1;
      load_output_n = 1'b0;
      force_clear_code_n = 1'b1;
      reset_pin_n = 1'b1;
      twos = 1'b0;
      cyc(5);
      rst = 1'b0;
      cyc(4);
      chk(dac_code, 16'h0000);
      for (int i = 0; i < 6; i++)
      begin
         code = (i == 0) ? 16'hffff : 16'($random(seed));
         upd_base = upd_seen;
         wr(`DSL_ADDR_DAC, code);
         chk(input_code, code);
         chk(dac_code, code);
         chk(output_code, out_of(code));
         chk(16'(upd_seen - upd_base), 16'h0001);
         last = code;
      end
      host.send({1'b0, `DSL_ADDR_CTRL, 20'h00002}, 24);
      cyc(8);
      twos = 1'b1;
      chk(output_code, out_of(last));
      // An unknown address, a frame one bit short and a readback request leave the code alone.
      upd_base = upd_seen;
      wr(3'h5, ~last);
      chk(dac_code, last);
      host.send(mk(`DSL_ADDR_DAC, ~last), 23);
      cyc(8);
      chk(dac_code, last);
      host.send({1'b1, `DSL_ADDR_DAC, ~last, 4'h0}, 24);
      cyc(8);
      chk(dac_code, last);
      chk(serial_out, 1'b1);
      chk(16'(upd_seen - upd_base), 16'h0000);
      load_output_n = 1'b1;
      code = 16'($random(seed));
      wr(`DSL_ADDR_DAC, code);
      chk(input_code, code);
      chk(dac_code, last);
      chk(output_code, out_of(last));
      chk(16'(upd_seen - upd_base), 16'h0000);
      load_output_n = 1'b0;
      cyc(6);
      chk(dac_code, code);
      chk(output_code, out_of(code));
      chk(16'(upd_seen - upd_base), 16'h0001);
      last = code;
      code = 16'($random(seed));
      upd_base = upd_seen;
      wr(`DSL_ADDR_CLR, code);
      chk(dac_code, last);
      chk(16'(upd_seen - upd_base), 16'h0000);
      force_clear_code_n = 1'b0;
      cyc(6);
      chk(dac_code, code);
      chk(output_code, out_of(code));
      force_clear_code_n = 1'b1;
      cyc(4);
      // A clear held for six clocks reloads the register on each of them.
      chk(16'(upd_seen - upd_base), 16'h0006);
      reset_pin_n = 1'b0;
      cyc(5);
      reset_pin_n = 1'b1;
      cyc(4);
      chk(dac_code, 16'h0000);
      chk(input_code, 16'h0000);
      chk(output_code, 16'h0000);
      twos = 1'b0;
      code = 16'($random(seed));
      wr(`DSL_ADDR_DAC, code);
      chk(output_code, out_of(code));
      end_of_test();
   end

   initial
   begin
      #2000000;
      errors++;
      end_of_test();
   end
endmodule
